// [rtl/cgm_pkg.sv]
// Package for the clock gating and main oscillator control block
//
// Overview of operation
// - Writing one to system disable bit 0 stops the processor clock (idle).
// - Writing one to system disable bit 6 gates off the USB host clock.
// - Writing one to system disable bit 7 gates off the USB device clock.
// - Writing one to system disable bits 8/9 stops programmable output 0/1.
// - System state bit 0 reads one while the processor clock runs.
// - System state bit 6 reads one while the USB host clock is enabled.
// - System state bit 7 reads one while the USB device clock is enabled.
// - System state bits 8/9 read one for each enabled programmable output.
// - Writing one to peripheral enable bits 2..31 starts that clock.
// - Writes to unimplemented peripheral bits change nothing.
// - Writing one to peripheral disable bits 2..31 stops that clock.
// - Peripheral state bits 2..31 read one for each running clock.
// - Oscillator control bit 0 enables the oscillator; keep bypass zero then.
// - Stable flag rises only after the programmed start-up time elapsed.
// - Oscillator control bit 1 bypasses the oscillator; keep enable zero then.
// - With bypass set the stable flag sets at once.
// - With enable and bypass both clear the stable flag resets.
// - Start-up wait is field bits 15:8 times eight slow clock cycles.
// - Measure register low 16 bits count main clocks over 16 slow periods.
// - Measure bit 16 reads one only once the stable flag is set and the count is valid.
// - System enable bits 8/9 start the matching programmable output.
`default_nettype none

package cgm_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] SYS_ENABLE_OFS = 8'h00;
    localparam logic [7:0] SYS_DISABLE_OFS = 8'h04;
    localparam logic [7:0] SYS_STATE_OFS = 8'h08;
    localparam logic [7:0] PERIPH_ENABLE_OFS = 8'h10;
    localparam logic [7:0] PERIPH_DISABLE_OFS = 8'h14;
    localparam logic [7:0] PERIPH_STATE_OFS = 8'h18;
    localparam logic [7:0] OSC_CTRL_OFS = 8'h20;
    localparam logic [7:0] MEASURE_OFS = 8'h24;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CPU_CLOCK_BIT = 0;
    localparam int USB_HOST_CLOCK_BIT = 6;
    localparam int USB_DEVICE_CLOCK_BIT = 7;
    localparam int PROG_OUT_ZERO_BIT = 8;
    localparam int PROG_OUT_ONE_BIT = 9;
    localparam int OSC_ENABLE_BIT = 0;
    localparam int OSC_BYPASS_BIT = 1;
    localparam int OSC_COUNT_LSB = 8;
    localparam int OSC_COUNT_MSB = 15;
    localparam int MAIN_FREQ_VALID_BIT = 16;

    // ----------------------------------------------------------------
    // Masks and reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] SYS_WRITE_MASK = 32'h0000_03C1;
    localparam logic [31:0] SYS_STATE_RESET = 32'h0000_0003;
    localparam logic [31:0] PERIPH_STATE_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIPH_ID_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] OSC_CTRL_MASK = 32'h0000_FF03;
    localparam logic [31:0] OSC_CTRL_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_HZ = 125_000_000;
    localparam int SLOW_CLK_HZ = 32_768;
    localparam int SLOW_DIV_CYCLES = SYS_CLK_HZ / SLOW_CLK_HZ;
    localparam int OSC_COUNT_SCALE = 8;
    localparam int MEASURE_SLOW_PERIODS = 16;

    // Gate enables handed to the clock tree
    typedef struct packed {
        logic cpuClk;
        logic usbHostClk;
        logic usbDeviceClk;
        logic [1:0] progOut;
        logic [31:0] periphClk;
    } cgm_gates_type;

    // Oscillator control lines towards the pad cell
    typedef struct packed {
        logic oscEnable;
        logic osc_bypass_a;
        logic oscStable;
    } cgm_osc_type;

    // Start-up sequencer states
    typedef enum logic [1:0] {
        OSC_OFF,
        OSC_WAIT,
        OSC_READY
    } cgm_osc_state_type;

endpackage : cgm_pkg

`default_nettype wire

// [rtl/cgm_clock_ctrl.sv]
// Clock gating, oscillator start-up and main clock measurement
`default_nettype none

module cgm_clock_ctrl
    import cgm_pkg::*;
#(
    parameter logic [31:0] PERIPH_IMPL = PERIPH_ID_MASK,
    parameter int SLOW_DIV = SLOW_DIV_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cpuWake,
    input wire logic mainClkPulse,
    output cgm_gates_type gates,
    output cgm_osc_type osc
);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdData_q;
    logic access;
    logic wrStrobe;
    logic [31:0] byteMask;
    logic [31:0] wrBits;
    logic [31:0] rdMux;

    // Registers of the block state
    logic [31:0] sysState_q;
    logic [31:0] periphState_q;
    logic [31:0] oscCtrl_q;
    logic stable_q;
    cgm_osc_state_type oscState_q;
    logic [10:0] startCnt_q;
    logic [15:0] slowDiv_q;
    logic slowTick_q;
    logic [3:0] measPeriods_q;
    logic [15:0] measCnt_q;
    logic [15:0] mainFreq_q;
    logic freqValid_q;
    logic measOpen_q;
    logic measClose;
    logic measEdge;

    // New request taken only while no ack is pending, so one ack per request
    assign access = wb_cyc_i && wb_stb_i && !ack_q;
    assign wrStrobe = access && wb_we_i;

    // Byte lanes qualify every write, W1 registers included
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            byteMask[i*8 +: 8] = {8{wb_sel_i[i]}};
        end
        wrBits = wb_dat_i & byteMask;
    end

    // ----------------------------------------------------------------
    // Wishbone acknowledge and read data
    // ----------------------------------------------------------------

    // Read multiplexer; write-only and unmapped offsets read zero
    always_comb
    begin
        case (wb_adr_i)
            SYS_STATE_OFS: rdMux = sysState_q;
            PERIPH_STATE_OFS: rdMux = periphState_q;
            OSC_CTRL_OFS: rdMux = oscCtrl_q;
            MEASURE_OFS: rdMux = {15'h0, freqValid_q, mainFreq_q};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // Every access, mapped or not, is acked one cycle after it is seen
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
            rdData_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= access;
            if (access && !wb_we_i)
            begin
                rdData_q <= rdMux;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;

    // ----------------------------------------------------------------
    // System clock gates
    // ----------------------------------------------------------------

    // One shared vector for the enable/disable pair; bit 1 is a fixed one
    // Wake sets the processor bit and wins over a disable in the same cycle
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sysState_q <= SYS_STATE_RESET;
        end
        else
        begin
            if (wrStrobe && wb_adr_i == SYS_DISABLE_OFS)
            begin
                sysState_q <= (sysState_q & ~(wrBits & SYS_WRITE_MASK))
                    | {31'h0, cpuWake};
            end
            else if (wrStrobe && wb_adr_i == SYS_ENABLE_OFS)
            begin
                sysState_q <= sysState_q | (wrBits & SYS_WRITE_MASK & ~32'h0000_0001)
                    | {31'h0, cpuWake};
            end
            else if (cpuWake)
            begin
                sysState_q[CPU_CLOCK_BIT] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Peripheral clock gates
    // ----------------------------------------------------------------

    // Unimplemented identifiers are masked so writes to them do nothing
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            periphState_q <= PERIPH_STATE_RESET;
        end
        else if (wrStrobe && wb_adr_i == PERIPH_ENABLE_OFS)
        begin
            periphState_q <= periphState_q | (wrBits & PERIPH_IMPL & PERIPH_ID_MASK);
        end
        else if (wrStrobe && wb_adr_i == PERIPH_DISABLE_OFS)
        begin
            periphState_q <= periphState_q & ~(wrBits & PERIPH_IMPL & PERIPH_ID_MASK);
        end
    end

    // ----------------------------------------------------------------
    // Oscillator control register
    // ----------------------------------------------------------------

    // Enable and bypass together is a software fault; bypass then dominates
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            oscCtrl_q <= OSC_CTRL_RESET;
        end
        else if (wrStrobe && wb_adr_i == OSC_CTRL_OFS)
        begin
            oscCtrl_q <= ((oscCtrl_q & ~byteMask) | wrBits) & OSC_CTRL_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Slow clock enable divider
    // ----------------------------------------------------------------

    // Slow clock exists only as a one-cycle enable derived from sys_clk
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            slowDiv_q <= 16'h0000;
            slowTick_q <= 1'b0;
        end
        else if (slowDiv_q == 16'(SLOW_DIV - 1))
        begin
            slowDiv_q <= 16'h0000;
            slowTick_q <= 1'b1;
        end
        else
        begin
            slowDiv_q <= slowDiv_q + 16'h0001;
            slowTick_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Oscillator start-up sequencer
    // ----------------------------------------------------------------

    // Counts slow ticks to one past count field times eight, then flags stable;
    // the first tick may come at once, so the extra one keeps the wait full length.
    // A start-up count change while waiting is taken on the fly.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            oscState_q <= OSC_OFF;
            startCnt_q <= 11'h000;
            stable_q <= 1'b0;
        end
        else if (oscCtrl_q[OSC_BYPASS_BIT])
        begin
            oscState_q <= OSC_READY;
            stable_q <= 1'b1;
        end
        else if (!oscCtrl_q[OSC_ENABLE_BIT])
        begin
            oscState_q <= OSC_OFF;
            startCnt_q <= 11'h000;
            stable_q <= 1'b0;
        end
        else
        begin
            case (oscState_q)
                OSC_OFF:
                begin
                    startCnt_q <= 11'h000;
                    oscState_q <= OSC_WAIT;
                end
                OSC_WAIT:
                begin
                    if (startCnt_q > 11'(oscCtrl_q[OSC_COUNT_MSB:OSC_COUNT_LSB] * OSC_COUNT_SCALE))
                    begin
                        oscState_q <= OSC_READY;
                        stable_q <= 1'b1;
                    end
                    else if (slowTick_q)
                    begin
                        startCnt_q <= startCnt_q + 11'h001;
                    end
                end
                OSC_READY:
                begin
                    stable_q <= 1'b1;
                end
                default:
                begin
                    oscState_q <= OSC_OFF;
                    stable_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Main clock frequency measurement
    // ----------------------------------------------------------------

    // Window edges: the first tick once stable, then every sixteenth tick
    assign measClose = slowTick_q && measOpen_q && measPeriods_q == 4'(MEASURE_SLOW_PERIODS - 1);
    assign measEdge = measClose || (slowTick_q && !measOpen_q);

    // Window opens only on a tick, so no result covers a partial first period.
    // A pulse on a window edge goes into the window that opens there, so none
    // is lost between windows; the counter saturates rather than wrapping.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            measOpen_q <= 1'b0;
            measPeriods_q <= 4'h0;
            measCnt_q <= 16'h0000;
            mainFreq_q <= 16'h0000;
            freqValid_q <= 1'b0;
        end
        else if (!stable_q)
        begin
            measOpen_q <= 1'b0;
            measPeriods_q <= 4'h0;
            measCnt_q <= 16'h0000;
            freqValid_q <= 1'b0;
        end
        else
        begin
            if (slowTick_q)
            begin
                measOpen_q <= 1'b1;
                measPeriods_q <= measOpen_q ? measPeriods_q + 4'h1 : 4'h0;
            end
            if (measClose)
            begin
                mainFreq_q <= measCnt_q;
                freqValid_q <= 1'b1;
            end
            if (measEdge)
            begin
                measCnt_q <= {15'h0, mainClkPulse};
            end
            else if (measOpen_q && mainClkPulse && measCnt_q != 16'hFFFF)
            begin
                measCnt_q <= measCnt_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign gates.cpuClk = sysState_q[CPU_CLOCK_BIT];
    assign gates.usbHostClk = sysState_q[USB_HOST_CLOCK_BIT];
    assign gates.usbDeviceClk = sysState_q[USB_DEVICE_CLOCK_BIT];
    assign gates.progOut = {sysState_q[PROG_OUT_ONE_BIT], sysState_q[PROG_OUT_ZERO_BIT]};
    assign gates.periphClk = periphState_q;
    assign osc.oscEnable = oscCtrl_q[OSC_ENABLE_BIT];
    assign osc.osc_bypass_a = oscCtrl_q[OSC_BYPASS_BIT];
    assign osc.oscStable = stable_q;

endmodule : cgm_clock_ctrl

`default_nettype wire

// [bench/cgm_clock_ctrl_sva.sv]
// Port-level assertions for the clock gating and oscillator control block
`default_nettype none

module cgm_clock_ctrl_sva
    import cgm_pkg::*;
#(
    parameter logic [31:0] PERIPH_IMPL = PERIPH_ID_MASK
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cpuWake,
    input wire logic mainClkPulse,
    input wire cgm_gates_type gates,
    input wire cgm_osc_type osc
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Decoded bus events
    // ----------------------------------------------------------------
    logic takeWr;
    logic rdAck;
    logic [4:0] sysGates;
    // Decoded once so each check below stays short
    assign takeWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rdAck = wb_ack_o && !wb_we_i;
    assign sysGates = {gates.progOut, gates.usbDeviceClk, gates.usbHostClk, gates.cpuClk};

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_sys_off: assert property (takeWr && wb_adr_i == SYS_DISABLE_OFS && wb_sel_i[1:0] == 2'h3
        && !cpuWake |=> (sysGates & $past({wb_dat_i[9:6], wb_dat_i[0]})) == 5'h0)
        else $error("system clock still on after disable");
    a_periph_on: assert property (takeWr && wb_adr_i == PERIPH_ENABLE_OFS && wb_sel_i == 4'hF
        |=> (gates.periphClk & $past(wb_dat_i) & PERIPH_IMPL) == ($past(wb_dat_i) & PERIPH_IMPL))
        else $error("peripheral clock not started");
    a_periph_off: assert property (takeWr && wb_adr_i == PERIPH_DISABLE_OFS && wb_sel_i == 4'hF
        |=> (gates.periphClk & $past(wb_dat_i)) == 32'h0) else $error("peripheral clock not stopped");
    a_unimpl_quiet: assert property ((gates.periphClk & ~PERIPH_IMPL) == 32'h0)
        else $error("unimplemented peripheral clock on");
    a_sys_state: assert property (rdAck && wb_adr_i == SYS_STATE_OFS
        |-> {wb_dat_o[9:6], wb_dat_o[0]} == $past(sysGates))
        else $error("system state read wrong");
    a_periph_state: assert property (rdAck && wb_adr_i == PERIPH_STATE_OFS
        |-> wb_dat_o == $past(gates.periphClk)) else $error("peripheral state read wrong");
    a_bypass_stable: assert property (osc.osc_bypass_a |=> osc.oscStable) else $error("bypass left flag low");
    a_clear_unstable: assert property (!osc.oscEnable && !osc.osc_bypass_a |=> !osc.oscStable)
        else $error("flag not cleared");
    a_no_early_flag: assert property ($rose(osc.oscEnable) && !osc.osc_bypass_a && !osc.oscStable
        |=> !osc.oscStable) else $error("flag rose before start-up");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");

    c_sys_off: cover property (takeWr && wb_adr_i == SYS_DISABLE_OFS);
    c_stable: cover property ($rose(osc.oscStable));
    c_bypass: cover property (osc.osc_bypass_a && osc.oscStable);
endmodule : cgm_clock_ctrl_sva

bind cgm_clock_ctrl cgm_clock_ctrl_sva #(.PERIPH_IMPL(PERIPH_IMPL)) i_sva (.sys_clk(sys_clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpuWake(cpuWake), .mainClkPulse(mainClkPulse),
    .gates(gates), .osc(osc));

`default_nettype wire

// [bench/cgm_partner.sv]
// Behavioural model of the processor core and the main clock source
`default_nettype none

module cgm_partner
    import cgm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic wakeReq,
    input wire cgm_osc_type osc,
    output var logic cpuWake,
    output var logic mainClkPulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_q;

    initial {cpuWake, mainClkPulse, phase_q} = 4'h0;

    // Main clock edges only while the pad reports a settled oscillator; one edge every 4 cycles
    always @(posedge sys_clk)
    begin
        phase_q <= phase_q + 2'h1;
        mainClkPulse <= osc.oscStable && (osc.oscEnable || osc.osc_bypass_a) && phase_q == 2'h3;
        cpuWake <= wakeReq;
    end
endmodule : cgm_partner

`default_nettype wire

// [bench/cgm_clock_ctrl_tb.sv]
// Self-checking bench for the clock gating and oscillator control block
`default_nettype none

module cgm_clock_ctrl_tb
    import cgm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IMPL = 32'h00FF_F0FC;
    localparam int DIV = 4;
    logic sys_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, wakeReq = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, sysExp, perExp, r;
    logic ack, cpuWake, mainClkPulse;
    logic [63:0] q;
    logic [63:0] expQ[$];
    cgm_gates_type gates;
    cgm_osc_type osc;
    int errors = 0;
    int nTests = 0;
    int bitList[5] = '{6, 7, 8, 9, 0};

    always #4 sys_clk = ~sys_clk;

    cgm_clock_ctrl #(.PERIPH_IMPL(IMPL), .SLOW_DIV(DIV)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cpuWake(cpuWake), .mainClkPulse(mainClkPulse), .gates(gates), .osc(osc));
    cgm_partner i_partner (.sys_clk(sys_clk), .wakeReq(wakeReq), .osc(osc), .cpuWake(cpuWake),
        .mainClkPulse(mainClkPulse));

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic printVerdict();
        if (errors == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : printVerdict

    // Request held until ack is sampled; a hung slave ends the run instead of stalling it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1)
        begin
            errors++;
            printVerdict();
        end
        else
        begin
            {cyc, stb} <= 2'b00;
            @(posedge sys_clk);
        end
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        expQ.push_back({m, exp});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask : rd

    // Oldest noted result is compared whenever the slave answers a read
    always @(posedge sys_clk)
        if (ack === 1'b1 && we === 1'b0)
        begin
            q = expQ.size() > 0 ? expQ.pop_front() : {32'h0, 32'hFFFF_FFFF};
            chk("read data", rdat & q[63:32], q[31:0]);
        end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h0FA4D0E2));
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(SYS_STATE_OFS, SYS_STATE_RESET, 32'h3C3);
        rd(OSC_CTRL_OFS, OSC_CTRL_RESET, 32'hFFFF_FFFF);
        rd(MEASURE_OFS, 32'h0, 32'h1_FFFF);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
        rd(8'h0C, 32'h0, 32'hFFFF_FFFF);
        // Zero writes and wrong byte lanes must leave the gates alone
        bus(1'b1, SYS_DISABLE_OFS, 32'h0, 4'hF);
        bus(1'b1, SYS_ENABLE_OFS, 32'h3C0, 4'hF);
        sysExp = 32'h3C3;
        rd(SYS_STATE_OFS, sysExp, 32'h3C3);
        bus(1'b1, SYS_DISABLE_OFS, 32'h300, 4'h1);
        rd(SYS_STATE_OFS, sysExp, 32'h3C3);
        foreach (bitList[i])
        begin
            bus(1'b1, SYS_DISABLE_OFS, 32'h1 << bitList[i], 4'hF);
            sysExp[bitList[i]] = 1'b0;
            rd(SYS_STATE_OFS, sysExp, 32'h3C3);
        end
        wakeReq <= 1'b1;
        @(posedge sys_clk);
        wakeReq <= 1'b0;
        repeat (3) @(posedge sys_clk);
        sysExp[0] = 1'b1;
        rd(SYS_STATE_OFS, sysExp, 32'h3C3);
        // Random enable and disable sets; unimplemented ids must stay off
        perExp = 32'h0;
        repeat (6)
        begin
            r = $urandom;
            bus(1'b1, PERIPH_ENABLE_OFS, r, 4'hF);
            perExp = perExp | (r & IMPL);
            rd(PERIPH_STATE_OFS, perExp, 32'hFFFF_FFFF);
            r = $urandom;
            bus(1'b1, PERIPH_DISABLE_OFS, r, 4'hF);
            perExp = perExp & ~r;
            rd(PERIPH_STATE_OFS, perExp, 32'hFFFF_FFFF);
        end
        bus(1'b1, PERIPH_STATE_OFS, 32'hFFFF_FFFF, 4'hF);
        rd(PERIPH_STATE_OFS, perExp, 32'hFFFF_FFFF);
        // Start-up count of 2 gives 2*8+1 slow ticks before the flag
        bus(1'b1, OSC_CTRL_OFS, 32'h0000_0201, 4'hF);
        rd(OSC_CTRL_OFS, 32'h201, 32'hFFFF_FFFF);
        repeat (2 * 8 * DIV - 6) @(posedge sys_clk);
        chk("stable early", 32'(osc.oscStable), 32'h0);
        for (int n = 0; n < 40 && osc.oscStable !== 1'b1; n++)
            @(posedge sys_clk);
        chk("stable late", 32'(osc.oscStable), 32'h1);
        repeat (3 * 16 * DIV) @(posedge sys_clk);
        rd(MEASURE_OFS, 32'h1_0000 | 32'(16 * DIV / 4), 32'h1_FFFF);
        bus(1'b1, OSC_CTRL_OFS, 32'h0, 4'hF);
        @(posedge sys_clk);
        chk("stable cleared", 32'(osc.oscStable), 32'h0);
        rd(MEASURE_OFS, 32'h0, 32'h1_0000);
        bus(1'b1, OSC_CTRL_OFS, 32'h0000_FF02, 4'hF);
        @(posedge sys_clk);
        chk("stable bypass", 32'(osc.oscStable), 32'h1);
        bus(1'b1, OSC_CTRL_OFS, 32'h0, 4'hF);
        chk("reads left", 32'(expQ.size()), 32'h0);
        printVerdict();
    end
endmodule : cgm_clock_ctrl_tb

`default_nettype wire
